/* sdc_pkg.sv */
// Package: register map, field positions and reset values for the converter controls
package sdc_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] SECOND_CONVERTER_CONTROL_OFS = 8'h06;
  localparam logic [7:0] THIRD_CONVERTER_CONTROL_OFS  = 8'h07;

  // ==========================================================
  // Field positions
  localparam int SDC_RSVD_BIT        = 7;
  localparam int SDC_SECOND_EN_BIT   = 6;
  localparam int SDC_SECOND_PWM_BIT  = 5;
  localparam int SDC_THIRD_PWM_BIT   = 6;
  localparam int SDC_THIRD_EN_BIT    = 5;
  localparam int SDC_VCODE_MSB       = 4;

  // ==========================================================
  // Reset values and codes
  localparam logic [4:0] SDC_VCODE_ZERO        = 5'h00;
  localparam logic [4:0] SDC_SECOND_VCODE_RST  = 5'h1f;
  localparam logic [4:0] SDC_THIRD_VCODE_DFLT  = 5'h1f;
  localparam logic       SDC_SECOND_EN_RST     = 1'h1;
  localparam logic       SDC_SECOND_PWM_RST    = 1'h0;
  localparam logic       SDC_THIRD_EN_RST      = 1'h1;
  localparam logic       SDC_THIRD_PWM_RST     = 1'h0;

  // Second converter voltage target select
  typedef enum logic [1:0] {
    SDC_VSEL_EXTERNAL,
    SDC_VSEL_TABLE,
    SDC_VSEL_MAX
  } sdc_vsel_type;

endpackage

/* sdc_ctl_if.sv */
// Interface: stored register fields bundle from register file to converter control
interface sdc_ctl_if;
  logic [6:0] second_reg;
  logic [6:0] third_reg;

  modport regs
  (
    output second_reg,
    output third_reg
  );
  modport ctl
  (
    input  second_reg,
    input  third_reg
  );
endinterface

/* sdc_regfile.sv */
// Register storage for both converter control registers
module sdc_regfile
  import sdc_pkg::*;
#(
  parameter logic [4:0] THIRD_VCODE_RST = SDC_THIRD_VCODE_DFLT
)
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       resetn,
  // Write port
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_addr,
  input  wire logic [7:0] wr_data,
  // Read port
  input  wire logic [7:0] rd_addr,
  output      logic [7:0] rd_data_ff,
  // Stored fields
  sdc_ctl_if.regs         ctl
);

  logic [6:0] second_ff;
  logic [6:0] third_ff;
  logic [6:0] nxt_second;
  logic [6:0] nxt_third;
  logic [7:0] nxt_rd_data;

  // ==========================================================
  // Write and read decode
  always_comb
  begin
    nxt_second = second_ff;
    nxt_third  = third_ff;
    // Top bit is never stored
    if (wr_en && wr_addr == SECOND_CONVERTER_CONTROL_OFS)
    begin
      nxt_second = wr_data[6:0];  // [R13]
    end
    if (wr_en && wr_addr == THIRD_CONVERTER_CONTROL_OFS)
    begin
      nxt_third = wr_data[6:0];  // [R13]
    end
    unique case (rd_addr)
      SECOND_CONVERTER_CONTROL_OFS: nxt_rd_data = {1'b0, second_ff};  // [R13]
      THIRD_CONVERTER_CONTROL_OFS:  nxt_rd_data = {1'b0, third_ff};  // [R13]
      default:                      nxt_rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      second_ff  <= {SDC_SECOND_EN_RST, SDC_SECOND_PWM_RST, SDC_SECOND_VCODE_RST};  // [R2] [R3]
      third_ff   <= {SDC_THIRD_PWM_RST, SDC_THIRD_EN_RST, THIRD_VCODE_RST};  // [R5] [R6] [R12]
      rd_data_ff <= 8'h00;
    end
    else
    begin
      second_ff  <= nxt_second;
      third_ff   <= nxt_third;
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign ctl.second_reg = second_ff;
  assign ctl.third_reg  = third_ff;

  a_rd_top_zero: assert property (@(posedge clock) disable iff (!resetn)
    rd_data_ff[SDC_RSVD_BIT] == 1'b0)  // [R13]
    else $error("Reserved read bit not zero");

endmodule

/* sdc_top.sv */
// Top: control registers and decoded controls for the second and flash supply converters
// Functional notes
// R1: Second code: 0 external, 1-F table, 1x max
// R2: Second D5 forces PWM, resets zero
// R3: Second D6 enables converter, resets one
// R4: Third converter auto PWM/PFM by default
// R5: Third D6 forces PWM, resets zero
// R6: Third enable at D5, resets one
// R7: Host writes code before setting enable
// R8: Zero code holds third converter disabled
// R9: Disabled with nonzero code closes pulldown
// R10: Zero code opens the pulldown switch
// R11: Third code 01=1.80V, +0.05V per step
// R12: Third reset code is factory constant
// R13: Bit D7 ignores writes, reads zero
module sdc_top
  import sdc_pkg::*;
#(
  parameter logic [4:0] THIRD_VCODE_RST = SDC_THIRD_VCODE_DFLT
)
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       resetn,
  // Register access from serial host interface
  input  wire logic       reg_wr_en,
  input  wire logic [7:0] reg_wr_addr,
  input  wire logic [7:0] reg_wr_data,
  input  wire logic [7:0] reg_rd_addr,
  output      logic [7:0] reg_rd_data_ff,
  // Second step-down converter controls
  output      logic       second_stepdown_converter_en_ff,
  output      logic       second_stepdown_converter_force_pwm_ff,
  output      logic       second_stepdown_converter_ext_fb_ff,
  output      logic [3:0] second_stepdown_converter_vstep_ff,
  output      logic       second_stepdown_converter_vmax_ff,
  // Flash supply converter controls
  output      logic       flash_supply_converter_en_ff,
  output      logic       flash_supply_converter_force_pwm_ff,
  output      logic [4:0] flash_supply_converter_vcode_ff,
  output      logic       flash_supply_converter_pulldown_ff
);

  sdc_ctl_if ctl_bus ();

  sdc_regfile #(
    .THIRD_VCODE_RST (THIRD_VCODE_RST)
  ) u_regs (
    .clock      (clock),
    .resetn     (resetn),
    .wr_en      (reg_wr_en),
    .wr_addr    (reg_wr_addr),
    .wr_data    (reg_wr_data),
    .rd_addr    (reg_rd_addr),
    .rd_data_ff (reg_rd_data_ff),
    .ctl        (ctl_bus.regs)
  );

  function automatic sdc_vsel_type sdc_second_vsel(input logic [4:0] code);
    if (code[SDC_VCODE_MSB])
      return SDC_VSEL_MAX;
    else if (code == SDC_VCODE_ZERO)
      return SDC_VSEL_EXTERNAL;
    else
      return SDC_VSEL_TABLE;
  endfunction

  logic [4:0]   second_code;
  logic [4:0]   third_code;
  logic         third_code_zero;
  logic         third_en_bit;
  sdc_vsel_type second_vsel;

  logic       nxt_second_en;
  logic       nxt_second_pwm;
  logic       nxt_second_ext;
  logic [3:0] nxt_second_vstep;
  logic       nxt_second_vmax;
  logic       nxt_third_en;
  logic       nxt_third_pwm;
  logic [4:0] nxt_third_vcode;
  logic       nxt_third_pd;

  // ==========================================================
  // Decode
  always_comb
  begin
    second_code     = ctl_bus.second_reg[SDC_VCODE_MSB:0];
    third_code      = ctl_bus.third_reg[SDC_VCODE_MSB:0];
    third_code_zero = (third_code == SDC_VCODE_ZERO);
    third_en_bit    = ctl_bus.third_reg[SDC_THIRD_EN_BIT];
    second_vsel     = sdc_second_vsel(second_code);
    nxt_second_en    = ctl_bus.second_reg[SDC_SECOND_EN_BIT];  // [R3]
    nxt_second_pwm   = ctl_bus.second_reg[SDC_SECOND_PWM_BIT];  // [R2]
    nxt_second_ext   = (second_vsel == SDC_VSEL_EXTERNAL);  // [R1]
    nxt_second_vmax  = (second_vsel == SDC_VSEL_MAX);  // [R1]
    // Step 1..15 means 1.80 V + 0.10 V*(step-1); 0 when not table
    nxt_second_vstep = (second_vsel == SDC_VSEL_TABLE) ? second_code[3:0] : 4'h0;  // [R1]
    // Host must program code before enable; zero code overrides enable
    nxt_third_en     = third_en_bit && !third_code_zero;  // [R6] [R7] [R8]
    // Auto PWM/PFM in the converter unless forced
    nxt_third_pwm    = ctl_bus.third_reg[SDC_THIRD_PWM_BIT];  // [R4] [R5]
    // Analog decodes 1.80 V + 0.05 V*(code-1)
    nxt_third_vcode  = third_code;  // [R11]
    nxt_third_pd     = !third_en_bit && !third_code_zero;  // [R9] [R10]
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      second_stepdown_converter_en_ff        <= SDC_SECOND_EN_RST;
      second_stepdown_converter_force_pwm_ff <= SDC_SECOND_PWM_RST;
      second_stepdown_converter_ext_fb_ff    <= 1'b0;
      second_stepdown_converter_vstep_ff     <= 4'h0;
      second_stepdown_converter_vmax_ff      <= 1'b1;
      // Factory code shows from reset; a zero factory code keeps it off
      flash_supply_converter_en_ff           <= SDC_THIRD_EN_RST && (THIRD_VCODE_RST != SDC_VCODE_ZERO);  // [R6] [R8]
      flash_supply_converter_force_pwm_ff    <= SDC_THIRD_PWM_RST;
      flash_supply_converter_vcode_ff        <= THIRD_VCODE_RST;  // [R12]
      flash_supply_converter_pulldown_ff     <= 1'b0;
    end
    else
    begin
      second_stepdown_converter_en_ff        <= nxt_second_en;
      second_stepdown_converter_force_pwm_ff <= nxt_second_pwm;
      second_stepdown_converter_ext_fb_ff    <= nxt_second_ext;
      second_stepdown_converter_vstep_ff     <= nxt_second_vstep;
      second_stepdown_converter_vmax_ff      <= nxt_second_vmax;
      flash_supply_converter_en_ff           <= nxt_third_en;
      flash_supply_converter_force_pwm_ff    <= nxt_third_pwm;
      flash_supply_converter_vcode_ff        <= nxt_third_vcode;
      flash_supply_converter_pulldown_ff     <= nxt_third_pd;
    end
  end

  // ==========================================================
  // Checks
  a_zero_code_off: assert property (@(posedge clock) disable iff (!resetn)
    ##1 $past(resetn) && $past(third_code_zero) |-> !flash_supply_converter_en_ff)  // [R8]
    else $error("Third converter enabled with zero code");

  a_pd_zero_open: assert property (@(posedge clock) disable iff (!resetn)
    ##1 $past(resetn) && $past(third_code_zero) |-> !flash_supply_converter_pulldown_ff)  // [R10]
    else $error("Pulldown closed with zero code");

  a_pd_when_off: assert property (@(posedge clock) disable iff (!resetn)
    ##1 $past(resetn) && $past(!third_en_bit && !third_code_zero) |-> flash_supply_converter_pulldown_ff)  // [R9]
    else $error("Pulldown open while disabled");

  a_pd_en_excl: assert property (@(posedge clock) disable iff (!resetn)
    !(flash_supply_converter_pulldown_ff && flash_supply_converter_en_ff))  // [R9]
    else $error("Pulldown and enable both active");

  a_third_wr_en: assert property (@(posedge clock) disable iff (!resetn)
    reg_wr_en && reg_wr_addr == THIRD_CONVERTER_CONTROL_OFS && reg_wr_data[4:0] != 5'h00
    |-> ##2 flash_supply_converter_en_ff == $past(reg_wr_data[5], 2))  // [R6]
    else $error("Third enable does not follow D5");

  a_third_pwm_wr: assert property (@(posedge clock) disable iff (!resetn)
    reg_wr_en && reg_wr_addr == THIRD_CONVERTER_CONTROL_OFS
    |-> ##2 flash_supply_converter_force_pwm_ff == $past(reg_wr_data[6], 2))  // [R5]
    else $error("Third force PWM does not follow D6");

  a_second_en_wr: assert property (@(posedge clock) disable iff (!resetn)
    reg_wr_en && reg_wr_addr == SECOND_CONVERTER_CONTROL_OFS
    |-> ##2 second_stepdown_converter_en_ff == $past(reg_wr_data[6], 2)
        && second_stepdown_converter_force_pwm_ff == $past(reg_wr_data[5], 2))  // [R2]
    else $error("Second enable or PWM wrong");

  a_second_vmax: assert property (@(posedge clock) disable iff (!resetn)
    reg_wr_en && reg_wr_addr == SECOND_CONVERTER_CONTROL_OFS && reg_wr_data[4]
    |-> ##2 second_stepdown_converter_vmax_ff && !second_stepdown_converter_ext_fb_ff)  // [R1]
    else $error("Second code top bit not max");

  a_second_ext: assert property (@(posedge clock) disable iff (!resetn)
    reg_wr_en && reg_wr_addr == SECOND_CONVERTER_CONTROL_OFS && reg_wr_data[4:0] == 5'h00
    |-> ##2 second_stepdown_converter_ext_fb_ff)  // [R1]
    else $error("Second zero code not external");

  a_third_vcode: assert property (@(posedge clock) disable iff (!resetn)
    reg_wr_en && reg_wr_addr == THIRD_CONVERTER_CONTROL_OFS
    |-> ##2 flash_supply_converter_vcode_ff == $past(reg_wr_data[4:0], 2))  // [R11]
    else $error("Third voltage code wrong");

  a_rd_second: assert property (@(posedge clock) disable iff (!resetn)
    reg_wr_en && reg_wr_addr == SECOND_CONVERTER_CONTROL_OFS && reg_rd_addr == SECOND_CONVERTER_CONTROL_OFS
    ##1 reg_rd_addr == SECOND_CONVERTER_CONTROL_OFS
    |-> ##1 reg_rd_data_ff == {1'b0, $past(reg_wr_data[6:0], 2)})  // [R13]
    else $error("Second readback wrong");

endmodule

/* sdc_host_model.sv */
// Host software model that programs the converter control registers
module sdc_host_model
(
  // Clock
  input  wire logic       clock,
  // Register access
  output      logic       reg_wr_en,
  output      logic [7:0] reg_wr_addr,
  output      logic [7:0] reg_wr_data,
  output      logic [7:0] reg_rd_addr,
  input  wire logic [7:0] reg_rd_data_ff
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // Bus cycles
  initial
  begin
    reg_wr_en   = 1'h0;
    reg_wr_addr = 8'h00;
    reg_wr_data = 8'h00;
    reg_rd_addr = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    reg_wr_en   = 1'h1;
    reg_wr_addr = a;
    reg_wr_data = d;
    @(posedge clock);
    #1;
    reg_wr_en   = 1'h0;
    // Scrambled so a stale byte is never taken as valid
    reg_wr_data = ~d;
  endtask

  // Code goes in first, enable only afterwards
  task automatic set_third(input logic pwm, input logic en, input logic [4:0] code);
    wr(8'h07, {1'h0, pwm, 1'h0, code});
    if (en)
      wr(8'h07, {1'h0, pwm, 1'h1, code});
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    #1;
    reg_rd_addr = a;
    repeat (2) @(posedge clock);
    #1;
    d = reg_rd_data_ff;
  endtask
endmodule

/* tb_stepdown_converter_control_regs.sv */
// Testbench for the converter control registers
module tb_stepdown_converter_control_regs import sdc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // Signals
  localparam logic [4:0] RST_CODE = 5'h15;
  logic       clock = 1'h0;
  logic       resetn = 1'h0;
  logic       wr_en, s_en, s_pwm, s_ext, s_vmax, t_en, t_pwm, t_pd;
  logic [7:0] wr_addr, wr_data, rd_addr, rdata, d;
  logic [3:0] s_vstep;
  logic [4:0] t_code;
  int         failures, tests_run, cycles;

  always #2.5 clock = ~clock;

  sdc_host_model host (.clock(clock), .reg_wr_en(wr_en), .reg_wr_addr(wr_addr), .reg_wr_data(wr_data),
    .reg_rd_addr(rd_addr), .reg_rd_data_ff(rdata));

  sdc_top #(.THIRD_VCODE_RST(RST_CODE)) dut (.clock(clock), .resetn(resetn), .reg_wr_en(wr_en),
    .reg_wr_addr(wr_addr), .reg_wr_data(wr_data), .reg_rd_addr(rd_addr), .reg_rd_data_ff(rdata),
    .second_stepdown_converter_en_ff(s_en), .second_stepdown_converter_force_pwm_ff(s_pwm),
    .second_stepdown_converter_ext_fb_ff(s_ext), .second_stepdown_converter_vstep_ff(s_vstep),
    .second_stepdown_converter_vmax_ff(s_vmax), .flash_supply_converter_en_ff(t_en),
    .flash_supply_converter_force_pwm_ff(t_pwm), .flash_supply_converter_vcode_ff(t_code),
    .flash_supply_converter_pulldown_ff(t_pd));

  // ==========================================================
  // Helpers
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic do_reset;
    resetn = 1'h0;
    repeat (4) @(posedge clock);
    #1;
    resetn = 1'h1;
    // Let the registered decode settle before the first check
    repeat (2) @(posedge clock);
    #1;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    chk("second en", 8'h01, {7'h0, s_en});
    chk("second pwm", 8'h00, {7'h0, s_pwm});
    chk("second ext vmax", 8'h01, {6'h0, s_ext, s_vmax});
    chk("third en pwm pd", 8'h04, {5'h0, t_en, t_pwm, t_pd});
    chk("third code", {3'h0, RST_CODE}, {3'h0, t_code});
    host.rd(8'h06, d);
    chk("second reset read", 8'h5f, d);
    host.rd(8'h07, d);
    chk("third reset read", {3'h1, RST_CODE}, d);
    $display("test reset done");
  endtask

  task automatic t_second;
    logic [4:0] c;
    logic [4:0] codes [5] = '{5'h00, 5'h01, 5'h0f, 5'h10, 5'h1a};
    for (int i = 0; i < 5; i++)
    begin
      c = codes[i];
      host.wr(SECOND_CONVERTER_CONTROL_OFS, {1'h1, i != 2, i[0], c});
      @(posedge clock);
      #1;
      chk("second ext", {7'h0, c == 5'h00}, {7'h0, s_ext});
      chk("second vstep", {4'h0, (c != 5'h00 && !c[4]) ? c[3:0] : 4'h0}, {4'h0, s_vstep});
      chk("second vmax", {7'h0, c[4]}, {7'h0, s_vmax});
      chk("second pwm en", {6'h0, i[0], i != 2}, {6'h0, s_pwm, s_en});
      host.rd(8'h06, d);
      chk("second read", {1'h0, i != 2, i[0], c}, d);
    end
    $display("test second done");
  endtask

  task automatic t_third;
    logic [6:0] v;
    logic [6:0] tbl [5] = '{7'h25, 7'h5f, 7'h20, 7'h40, 7'h21};
    for (int i = 0; i < 5; i++)
    begin
      v = tbl[i];
      host.set_third(v[6], v[5], v[4:0]);
      @(posedge clock);
      #1;
      chk("third en", {7'h0, v[5] && v[4:0] != 5'h00}, {7'h0, t_en});
      chk("third pd", {7'h0, !v[5] && v[4:0] != 5'h00}, {7'h0, t_pd});
      chk("third pwm", {7'h0, v[6]}, {7'h0, t_pwm});
      chk("third code", {3'h0, v[4:0]}, {3'h0, t_code});
      host.rd(8'h07, d);
      chk("third read", {1'h0, v}, d);
    end
    $display("test third done");
  endtask

  task automatic t_unmapped;
    host.wr(8'h08, 8'h55);
    host.wr(8'h05, 8'h00);
    host.wr(8'h07, 8'ha1);
    host.rd(8'h08, d);
    chk("unmapped read", 8'h00, d);
    host.rd(8'h07, d);
    chk("third after stray", 8'h21, d);
    host.rd(8'h06, d);
    chk("second after stray", 8'h5a, d);
    $display("test unmapped done");
  endtask

  // ==========================================================
  // Sequence and watchdog
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      test_done();
    end
  end

  initial
  begin
    do_reset();
    t_reset();
    t_second();
    t_third();
    t_unmapped();
    do_reset();
    t_reset();
    test_done();
  end
endmodule
